/* File: verilog/smcg_pkg.sv */
// shared constants and types of the sleep clock gate block
package smcg_pkg;

  // register byte offsets from the system control base
  localparam logic [31:0] SYS_CTRL_BASE   = 32'h400f_e000;
  localparam int          REG_ADDR_W      = 12;
  localparam logic [11:0] OFS_RUN_GATE    = 12'h104;
  localparam logic [11:0] OFS_SLEEP_GATE  = 12'h114;
  localparam logic [11:0] OFS_DEEP_GATE   = 12'h124;
  localparam logic [11:0] OFS_CLOCK_CFG   = 12'h060;
  localparam logic [11:0] OFS_GATE_STATUS = 12'h1f0;

  // reset values
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic        AUTO_RESET = 1'h0;

  // field positions of the gating registers
  localparam int BIT_ASYNC0  = 0;
  localparam int BIT_ASYNC1  = 1;
  localparam int BIT_SYNC0   = 4;
  localparam int BIT_TWOWIRE = 12;
  localparam int BIT_CNT0    = 16;
  localparam int BIT_CNT1    = 17;
  localparam int BIT_CNT2    = 18;
  localparam int BIT_COMPARATOR_ZERO_GATE   = 24;
  // auto gating bit in the clock configuration register
  localparam int BIT_AUTO_GATE = 11;

  // status register fields
  localparam int STAT_MODE_LSB = 8;

  // controlled units, one enable each
  localparam int NUM_UNITS = 8;

  // implemented gating bits; all others stay zero
  localparam logic [31:0] GATE_WR_MASK =
    (32'h1 << BIT_ASYNC0) | (32'h1 << BIT_ASYNC1) |
    (32'h1 << BIT_SYNC0) | (32'h1 << BIT_TWOWIRE) |
    (32'h1 << BIT_CNT0) | (32'h1 << BIT_CNT1) |
    (32'h1 << BIT_CNT2) | (32'h1 << BIT_COMPARATOR_ZERO_GATE);

  // power mode as seen by the gating logic
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} smcg_mode_e;

  // unit index to gating bit position
  function automatic int unit_bit(input int unit);
    case (unit)
      0: unit_bit = BIT_ASYNC0;
      1: unit_bit = BIT_ASYNC1;
      2: unit_bit = BIT_SYNC0;
      3: unit_bit = BIT_TWOWIRE;
      4: unit_bit = BIT_CNT0;
      5: unit_bit = BIT_CNT1;
      6: unit_bit = BIT_CNT2;
      default: unit_bit = BIT_COMPARATOR_ZERO_GATE;
    endcase
  endfunction : unit_bit

endpackage : smcg_pkg

/* File: verilog/smcg_fault_check.sv */
// access checker: faults accesses to units whose clock is off
`timescale 1ns/1ns
module smcg_fault_check (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  // access request from the bus fabric
  input  wire logic                          acc_valid,
  input  wire logic [2:0]                    acc_unit,
  // delivered unit enables
  input  wire logic [smcg_pkg::NUM_UNITS-1:0] unit_en,
  // answer, one cycle after the request
  output logic                               fault,
  output logic                               grant
);
  import smcg_pkg::*;

  typedef struct packed {
    logic fault;
    logic grant;
  } smcg_chk_s;

  smcg_chk_s st;
  smcg_chk_s next_st;

  // gated unit answers with a fault, never a grant
  always_comb begin
    next_st = '{default: 1'h0};
    next_st.fault = acc_valid & ~unit_en[acc_unit];
    next_st.grant = acc_valid & unit_en[acc_unit];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{default: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign fault = st.fault;
  assign grant = st.grant;

  property p_fault_off;
    @(posedge clk_sys) disable iff (!arst_n)
    (acc_valid && !unit_en[acc_unit]) |=> (fault && !grant);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("no fault on gated unit");

  property p_grant_on;
    @(posedge clk_sys) disable iff (!arst_n)
    (acc_valid && unit_en[acc_unit]) |=> (grant && !fault);
  endproperty
  a_grant_on: assert property (p_grant_on) else $error("clocked unit refused");

endmodule : smcg_fault_check

/* File: verilog/smcg_gate.sv */
// sleep mode clock gating register block with run and deep-sleep sets
//
// Contract
// - enable bit one clocks its unit; zero leaves it unclocked
// - access to an unclocked unit answers with a bus fault
// - every gating bit is zero after reset
// - separate gating sets for run, sleep and deep-sleep
// - sleep sets apply only while auto gating is set
// - bit 24 is the read-write comparator zero enable
// - bits 0,1,4,12,16,17,18 enable serial, two-wire and counter units
// - sleep register at offset 0x114, 32 bits, reset zero
// - reserved bits are read-only and read zero
// - unused bit positions exist as reserved positions
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module smcg_gate (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           arst_n,
  // register port
  input  wire logic [smcg_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  // power mode from the core
  input  wire logic                           sleep_req,
  input  wire logic                           deep_sleep_req,
  // peripheral access check
  input  wire logic                           periph_acc,
  input  wire logic [2:0]                     periph_unit,
  output logic                                periph_fault,
  output logic                                periph_grant,
  // delivered unit clock enables
  output logic                                async_serial_zero_gate,
  output logic                                async_serial_one_gate,
  output logic                                sync_serial_zero_gate,
  output logic                                two_wire_zero_gate,
  output logic                                gp_counter_zero_gate,
  output logic                                gp_counter_one_gate,
  output logic                                gp_counter_two_gate,
  output logic                                comparator_zero_gate
);
  import smcg_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0]           run_gate;
    logic [31:0]           sleep_gate;
    logic [31:0]           deep_gate;
    logic                  auto_gate;
    smcg_mode_e            mode;
    logic [NUM_UNITS-1:0]  unit_en;
    logic [31:0]           rdata;
  } smcg_state_s;

  smcg_state_s st;
  smcg_state_s next_st;

  // gating word to per-unit enables
  function automatic logic [NUM_UNITS-1:0] units_of(input logic [31:0] gate);
    units_of = '0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      units_of[i] = gate[unit_bit(i)];
    end
  endfunction : units_of

  // gating word that applies in the current mode
  logic [31:0] active_gate;

  // without auto gating the run set stays in force in every mode
  always_comb begin
    active_gate = st.run_gate;
    if (st.auto_gate) begin
      case (st.mode)
        MODE_SLEEP: active_gate = st.sleep_gate;
        MODE_DEEP:  active_gate = st.deep_gate;
        default:    active_gate = st.run_gate;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    // register writes; reserved positions are never stored
    if (reg_wr) begin
      if (reg_addr == OFS_RUN_GATE) begin
        next_st.run_gate = reg_wdata & GATE_WR_MASK;
      end else if (reg_addr == OFS_SLEEP_GATE) begin
        next_st.sleep_gate = reg_wdata & GATE_WR_MASK;
      end else if (reg_addr == OFS_DEEP_GATE) begin
        next_st.deep_gate = reg_wdata & GATE_WR_MASK;
      end else if (reg_addr == OFS_CLOCK_CFG) begin
        next_st.auto_gate = reg_wdata[BIT_AUTO_GATE];
      end
    end
    // register reads; unmapped offsets read zero
    if (reg_rd) begin
      if (reg_addr == OFS_RUN_GATE) begin
        next_st.rdata = st.run_gate;
      end else if (reg_addr == OFS_SLEEP_GATE) begin
        next_st.rdata = st.sleep_gate;
      end else if (reg_addr == OFS_DEEP_GATE) begin
        next_st.rdata = st.deep_gate;
      end else if (reg_addr == OFS_CLOCK_CFG) begin
        next_st.rdata[BIT_AUTO_GATE] = st.auto_gate;
      end else if (reg_addr == OFS_GATE_STATUS) begin
        next_st.rdata[NUM_UNITS-1:0] = st.unit_en;
        next_st.rdata[STAT_MODE_LSB +: 2] = st.mode;
      end
    end
    // deep-sleep request outranks sleep
    if (deep_sleep_req) begin
      next_st.mode = MODE_DEEP;
    end else if (sleep_req) begin
      next_st.mode = MODE_SLEEP;
    end else begin
      next_st.mode = MODE_RUN;
    end
    // enables follow the applying set one cycle later
    next_st.unit_en = units_of(active_gate);
  end

  // everything starts unclocked
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st.run_gate   <= GATE_RESET;
      st.sleep_gate <= GATE_RESET;
      st.deep_gate  <= GATE_RESET;
      st.auto_gate  <= AUTO_RESET;
      st.mode       <= MODE_RUN;
      st.unit_en    <= '0;
      st.rdata      <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata              = st.rdata;
  assign async_serial_zero_gate = st.unit_en[0];
  assign async_serial_one_gate  = st.unit_en[1];
  assign sync_serial_zero_gate  = st.unit_en[2];
  assign two_wire_zero_gate     = st.unit_en[3];
  assign gp_counter_zero_gate   = st.unit_en[4];
  assign gp_counter_one_gate    = st.unit_en[5];
  assign gp_counter_two_gate    = st.unit_en[6];
  assign comparator_zero_gate   = st.unit_en[7];

  // access checker sees the enables actually delivered
  smcg_fault_check u_fault_check (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .acc_valid (periph_acc),
    .acc_unit  (periph_unit),
    .unit_en   (st.unit_en),
    .fault     (periph_fault),
    .grant     (periph_grant)
  );

  ////////////////////////////////////////////////////////////////////
  // checks

  // helper: any sleep register write seen since reset
  logic sleep_written;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sleep_written <= 1'h0;
    end else if (reg_wr && reg_addr == OFS_SLEEP_GATE) begin
      sleep_written <= 1'h1;
    end
  end

  // sleep set holds its reset word until the first write
  property p_reset_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    !sleep_written |-> (st.sleep_gate == GATE_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("sleep set not zero");

  // a write read back at once returns the masked word
  property p_sleep_readback;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_SLEEP_GATE)
      ##1 (reg_rd && !reg_wr && reg_addr == OFS_SLEEP_GATE)
      |=> (reg_rdata == ($past(reg_wdata, 2) & GATE_WR_MASK));
  endproperty
  a_sleep_readback: assert property (p_sleep_readback) else $error("sleep readback wrong");

  // reserved positions of every set read zero
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && (reg_addr == OFS_RUN_GATE || reg_addr == OFS_SLEEP_GATE
                || reg_addr == OFS_DEEP_GATE))
      |=> ((reg_rdata & ~GATE_WR_MASK) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // comparator enable is stored as written
  property p_comp_bit;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_SLEEP_GATE)
      |=> (st.sleep_gate[BIT_COMPARATOR_ZERO_GATE] == $past(reg_wdata[BIT_COMPARATOR_ZERO_GATE]));
  endproperty
  a_comp_bit: assert property (p_comp_bit) else $error("comparator bit lost");

  // serial, two-wire and counter enables are stored as written
  property p_counter_bits;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_SLEEP_GATE)
      |=> (st.sleep_gate[BIT_CNT2:BIT_CNT0] == $past(reg_wdata[BIT_CNT2:BIT_CNT0])
           && st.sleep_gate[BIT_TWOWIRE] == $past(reg_wdata[BIT_TWOWIRE])
           && st.sleep_gate[BIT_SYNC0] == $past(reg_wdata[BIT_SYNC0])
           && st.sleep_gate[BIT_ASYNC1:BIT_ASYNC0] == $past(reg_wdata[BIT_ASYNC1:BIT_ASYNC0]));
  endproperty
  a_counter_bits: assert property (p_counter_bits) else $error("unit bit lost");

  // writes to other offsets leave the sleep set alone
  property p_sets_apart;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr != OFS_SLEEP_GATE) |=> $stable(st.sleep_gate);
  endproperty
  a_sets_apart: assert property (p_sets_apart) else $error("sleep set disturbed");

  // without auto gating only the run set reaches the units
  property p_no_auto;
    @(posedge clk_sys) disable iff (!arst_n)
    !st.auto_gate |=> (st.unit_en == units_of($past(st.run_gate)));
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("sleep set used without auto");

  // sleep with auto gating delivers the sleep set
  property p_sleep_select;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.auto_gate && st.mode == MODE_SLEEP)
      |=> (st.unit_en == units_of($past(st.sleep_gate)));
  endproperty
  a_sleep_select: assert property (p_sleep_select) else $error("sleep enables wrong");

  // a sleep request reaches the enables two cycles later
  property p_mode_track;
    @(posedge clk_sys) disable iff (!arst_n)
    (sleep_req && !deep_sleep_req) ##1 st.auto_gate
      |=> (st.unit_en == units_of($past(st.sleep_gate)));
  endproperty
  a_mode_track: assert property (p_mode_track) else $error("sleep entry missed");

  // the status word is read-only; writing it changes no set
  property p_unmapped_wr;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_GATE_STATUS)
      |=> ($stable(st.run_gate) && $stable(st.deep_gate));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("status write stored");

  // deep-sleep with auto gating delivers the deep-sleep set
  property p_deep_select;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.auto_gate && st.mode == MODE_DEEP)
      |=> (st.unit_en == units_of($past(st.deep_gate)));
  endproperty
  a_deep_select: assert property (p_deep_select) else $error("deep enables wrong");

  // run with auto gating still delivers the run set
  property p_run_select;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.auto_gate && st.mode == MODE_RUN)
      |=> (st.unit_en == units_of($past(st.run_gate)));
  endproperty
  a_run_select: assert property (p_run_select) else $error("run enables wrong");

  // run set stores the masked write word
  property p_run_store;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_RUN_GATE)
      |=> (st.run_gate == ($past(reg_wdata) & GATE_WR_MASK));
  endproperty
  a_run_store: assert property (p_run_store) else $error("run set not stored");

  // deep-sleep set stores the masked write word
  property p_deep_store;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_DEEP_GATE)
      |=> (st.deep_gate == ($past(reg_wdata) & GATE_WR_MASK));
  endproperty
  a_deep_store: assert property (p_deep_store) else $error("deep set not stored");

  // deep-sleep request outranks a sleep request
  property p_mode_order;
    @(posedge clk_sys) disable iff (!arst_n)
    deep_sleep_req |=> (st.mode == MODE_DEEP);
  endproperty
  a_mode_order: assert property (p_mode_order) else $error("deep request lost");

  // auto gating bit follows its write
  property p_auto_store;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_wr && reg_addr == OFS_CLOCK_CFG)
      |=> (st.auto_gate == $past(reg_wdata[BIT_AUTO_GATE]));
  endproperty
  a_auto_store: assert property (p_auto_store) else $error("auto bit not stored");

  // clock configuration reads show the auto gating bit alone
  property p_cfg_read;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == OFS_CLOCK_CFG)
      |=> (reg_rdata == ({31'h0000_0000, $past(st.auto_gate)} << BIT_AUTO_GATE));
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config word wrong");

  // status reads show the enables and mode of the read cycle
  property p_status_read;
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == OFS_GATE_STATUS)
      |=> (reg_rdata[NUM_UNITS-1:0] == $past(st.unit_en)
           && reg_rdata[STAT_MODE_LSB +: 2] == $past(st.mode));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word wrong");

  // read data falls back to zero when no read is made
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data");

  // enables move only when a set, the mode or the auto bit moved
  property p_enable_lag;
    @(posedge clk_sys) disable iff (!arst_n)
    ($stable(st.run_gate) && $stable(st.sleep_gate) && $stable(st.deep_gate)
     && $stable(st.auto_gate) && $stable(st.mode))
      |=> $stable(st.unit_en);
  endproperty
  a_enable_lag: assert property (p_enable_lag) else $error("enables moved alone");

endmodule : smcg_gate

/* File: testbench/sleep_mode_clock_gating_tb_top.sv */
// self-checking bench of the sleep clock gate register block
`timescale 1ns/1ns
module sleep_mode_clock_gating_tb_top;
  import smcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // stimulus, observed outputs and tallies
  logic        clk_sys        = 1'h0;
  logic        arst_n         = 1'h0;
  logic [11:0] reg_addr       = 12'h000;
  logic [31:0] reg_wdata      = 32'h0000_0000;
  logic        reg_wr         = 1'h0;
  logic        reg_rd         = 1'h0;
  logic        sleep_req      = 1'h0;
  logic        deep_sleep_req = 1'h0;
  logic        periph_acc     = 1'h0;
  logic [2:0]  periph_unit    = 3'h0;
  wire  [31:0] reg_rdata;
  wire         periph_fault;
  wire         periph_grant;
  wire  [7:0]  en;
  logic [31:0] rd;
  int          err_total      = 0;
  int          n_compared     = 0;
  // words chosen so every mode delivers a different unit set
  localparam logic [31:0] W_RUN = 32'h0000_1001;
  localparam logic [31:0] W_SLP = 32'h0107_0000;
  localparam logic [31:0] W_DPS = 32'h0000_0012;

  always #5 clk_sys = ~clk_sys;

  smcg_gate uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .periph_acc(periph_acc), .periph_unit(periph_unit),
    .periph_fault(periph_fault), .periph_grant(periph_grant),
    .async_serial_zero_gate(en[0]), .async_serial_one_gate(en[1]), .sync_serial_zero_gate(en[2]),
    .two_wire_zero_gate(en[3]), .gp_counter_zero_gate(en[4]), .gp_counter_one_gate(en[5]),
    .gp_counter_two_gate(en[6]), .comparator_zero_gate(en[7]));

  ////////////////////////////////////////////////////////////////////////
  // expected unit enables of a gating word, in access index order
  function automatic logic [7:0] exp_en(input logic [31:0] w);
    return {w[BIT_COMPARATOR_ZERO_GATE], w[BIT_CNT2], w[BIT_CNT1], w[BIT_CNT0],
            w[BIT_TWOWIRE], w[BIT_SYNC0], w[BIT_ASYNC1], w[BIT_ASYNC0]};
  endfunction : exp_en

  // compare tasks, one per kind of result
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bits

  // register bus cycles; read data is taken only in the cycle after the strobe
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : bus_wr

  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : bus_rd

  // mode change; enables follow two cycles later, one spare
  task automatic set_mode(input logic s, input logic d);
    @(posedge clk_sys);
    sleep_req <= s;
    deep_sleep_req <= d;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_state();
    logic [11:0] ofs [5] = '{OFS_RUN_GATE, OFS_SLEEP_GATE, OFS_DEEP_GATE, OFS_CLOCK_CFG, OFS_GATE_STATUS};
    foreach (ofs[i]) begin
      bus_rd(ofs[i], rd);
      chk_word(rd, 32'h0000_0000, "reset word");
    end
    chk_bits(en, 8'h00, "reset enables");
    $display("test reset_state done");
  endtask : t_reset_state

  task automatic t_field_map();
    for (int i = 0; i < 32; i++) begin
      bus_wr(OFS_SLEEP_GATE, 32'h1 << i);
      bus_rd(OFS_SLEEP_GATE, rd);
      chk_word(rd, (32'h1 << i) & 32'h0107_1013, "single bit");
    end
    bus_wr(OFS_SLEEP_GATE, 32'hffff_ffff);
    bus_rd(OFS_SLEEP_GATE, rd);
    chk_word(rd, 32'h0107_1013, "all ones");
    bus_wr(OFS_RUN_GATE, W_RUN);
    bus_wr(OFS_SLEEP_GATE, W_SLP);
    bus_wr(OFS_DEEP_GATE, W_DPS);
    bus_wr(12'h118, 32'hffff_ffff);
    bus_rd(12'h118, rd);
    chk_word(rd, 32'h0000_0000, "unmapped");
    bus_rd(OFS_RUN_GATE, rd);
    chk_word(rd, W_RUN, "run word");
    bus_rd(OFS_SLEEP_GATE, rd);
    chk_word(rd, W_SLP, "sleep word");
    bus_rd(OFS_DEEP_GATE, rd);
    chk_word(rd, W_DPS, "deep word");
    $display("test field_map done");
  endtask : t_field_map

  // write then read with no gap; the read word stands one cycle only
  task automatic t_back_to_back();
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= OFS_SLEEP_GATE;
    reg_wdata <= 32'h5a5a_5a5a;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk_word(reg_rdata, 32'h5a5a_5a5a & 32'h0107_1013, "write then read");
    @(posedge clk_sys);
    #1 chk_word(reg_rdata, 32'h0000_0000, "read word released");
    // status word is read-only; a write there must touch no set
    bus_wr(OFS_GATE_STATUS, 32'hffff_ffff);
    bus_rd(OFS_GATE_STATUS, rd);
    chk_word(rd, {24'h00_0000, exp_en(W_RUN)}, "status after write");
    bus_rd(OFS_RUN_GATE, rd);
    chk_word(rd, W_RUN, "run word kept");
    bus_wr(OFS_SLEEP_GATE, W_SLP);
    $display("test back_to_back done");
  endtask : t_back_to_back

  // access every unit; unclocked ones must fault, clocked ones granted
  task automatic t_access(input logic [7:0] exp);
    for (int u = 0; u < 8; u++) begin
      @(posedge clk_sys);
      periph_acc <= 1'h1;
      periph_unit <= u[2:0];
      @(posedge clk_sys);
      periph_acc <= 1'h0;
      #1 chk_bits({6'h0, periph_fault, periph_grant}, exp[u] ? 8'h01 : 8'h02, "access");
    end
  endtask : t_access

  task automatic t_modes();
    set_mode(1'h1, 1'h0);
    chk_bits(en, exp_en(W_RUN), "sleep without auto");
    bus_wr(OFS_CLOCK_CFG, 32'hffff_ffff);
    bus_rd(OFS_CLOCK_CFG, rd);
    chk_word(rd, 32'h1 << BIT_AUTO_GATE, "auto bit");
    repeat (2) @(posedge clk_sys);
    #1 chk_bits(en, exp_en(W_SLP), "sleep enables");
    bus_rd(OFS_GATE_STATUS, rd);
    chk_word(rd, {22'h0, 2'h1, exp_en(W_SLP)}, "sleep status");
    t_access(exp_en(W_SLP));
    set_mode(1'h1, 1'h1);
    chk_bits(en, exp_en(W_DPS), "deep enables");
    t_access(exp_en(W_DPS));
    set_mode(1'h0, 1'h0);
    chk_bits(en, exp_en(W_RUN), "run enables");
    t_access(exp_en(W_RUN));
    $display("test modes done");
  endtask : t_modes

  task automatic t_rereset();
    @(posedge clk_sys);
    arst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    #1 chk_bits(en, 8'h00, "enables after reset");
    t_reset_state();
    $display("test rereset done");
  endtask : t_rereset

  ////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_reset_state();
    t_field_map();
    t_back_to_back();
    t_modes();
    t_rereset();
    end_of_test();
  end

  // whole run is a few hundred cycles; allow about twenty times that
  initial begin
    #50000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : sleep_mode_clock_gating_tb_top
